/* File: verilog/pfm_defs.vh */
`ifndef PFM_DEFS_VH
`define PFM_DEFS_VH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define PFM_IDX_CAP_ONE 10'h044
`define PFM_IDX_RES_THREE 10'h045
`define PFM_IDX_CAP_THREE 10'h046
`define PFM_IDX_SECONDARY_REF_CONTROL 10'h048
`define PFM_IDX_MARGIN_CTRL 10'h056
`define PFM_IDX_STEP_ONE_HIGH 10'h058
`define PFM_IDX_STEP_ONE_LOW 10'h059
`define PFM_IDX_SW_HIGH 10'h068
`define PFM_IDX_SW_LOW 10'h069

// ****************************************
// Field positions
// ****************************************
`define PFM_CAP_CODE_MSB 2
`define PFM_RES_CODE_MSB 6
`define PFM_RES_CODE_LSB 1
`define PFM_FRAC_BIT 0
`define PFM_SEC_RSV_HI_BIT 5
`define PFM_DOUBLER_BIT 4
`define PFM_SEC_RSV_LO_MSB 3
`define PFM_READBACK_MSB 6
`define PFM_READBACK_LSB 4
`define PFM_OPTION_MSB 3
`define PFM_OPTION_LSB 2
`define PFM_OFFSET_HIGH_MSB 1

// ****************************************
// Reset values
// ****************************************
`define PFM_RST_CAP_CODE 3'h0
`define PFM_RST_RES_CODE 6'h00
`define PFM_RST_FRAC 1'b0
`define PFM_RST_SEC_RSV_HI 1'b0
`define PFM_RST_DOUBLER 1'b1
`define PFM_RST_SEC_RSV_LO 4'h8
`define PFM_RST_OPTION 2'h0
`define PFM_RST_STEP_ONE_HIGH 2'h0
`define PFM_RST_STEP_ONE_LOW 8'hDE
`define PFM_RST_SW_HIGH 2'h0
`define PFM_RST_SW_LOW 8'h00

// ****************************************
// Margin option codes and steps
// ****************************************
`define PFM_OPT_GATED 2'h0
`define PFM_OPT_PIN_ONLY 2'h1
`define PFM_OPT_SOFTWARE 2'h2
`define PFM_STEP_NOMINAL 3'h3

// ****************************************
// Bus responses
// ****************************************
`define PFM_RESP_OKAY 2'h0
`define PFM_RESP_SLVERR 2'h2

`endif

/* File: verilog/pfm_pin_sync.v */
`timescale 1ns/1ps
`include "pfm_defs.vh"

module pfm_pin_sync #(
	parameter WIDTH = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] pin_level
);

	reg [WIDTH-1:0] stage_one;
	reg [WIDTH-1:0] stage_two;
	reg [WIDTH-1:0] stage_three;

	// ****************************************
	// Three stages per bit
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge aclk) begin
				if (!aresetn) begin
					stage_one[i] <= 1'b0;
					stage_two[i] <= 1'b0;
					stage_three[i] <= 1'b0;
				end else begin
					stage_one[i] <= pin_in[i];
					stage_two[i] <= stage_one[i];
					stage_three[i] <= stage_two[i];
				end
			end
		end
	endgenerate

	// Whole vector must agree, so a step code never tears between bits
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_level <= {WIDTH{1'b0}};
		end else if (stage_two == stage_three) begin
			pin_level <= stage_three;
		end
	end

endmodule // pfm_pin_sync

/* File: verilog/pfm_margin_sel.v */
`timescale 1ns/1ps
`include "pfm_defs.vh"

module pfm_margin_sel (
	input wire aclk,
	input wire aresetn,
	input wire [1:0] option,
	input wire gate_level,
	input wire [2:0] step_level,
	output reg [2:0] applied_step,
	output reg use_software
);

	reg [2:0] next_applied_step;
	reg next_use_software;

	// ****************************************
	// Offset source choice
	// ****************************************
	always @* begin
		next_applied_step = `PFM_STEP_NOMINAL;
		next_use_software = 1'b0;
		case (option)
			`PFM_OPT_GATED: begin
				if (!gate_level) begin
					next_applied_step = step_level;
				end else begin
					next_applied_step = `PFM_STEP_NOMINAL;
				end
			end
			`PFM_OPT_PIN_ONLY: begin
				next_applied_step = step_level;
			end
			`PFM_OPT_SOFTWARE: begin
				next_use_software = 1'b1;
			end
			default: begin
				// Undefined option parks on nominal loading
				next_applied_step = `PFM_STEP_NOMINAL;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			applied_step <= `PFM_STEP_NOMINAL;
			use_software <= 1'b0;
		end else begin
			applied_step <= next_applied_step;
			use_software <= next_use_software;
		end
	end

endmodule // pfm_margin_sel

/* File: verilog/pfm_regs.v */
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pfm_defs.vh"

module pfm_regs (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire margin_gate_pin,
	input wire [2:0] margin_step_pin,
	output reg [2:0] filter_cap_one_code,
	output reg [5:0] filter_res_three_code,
	output reg filter_fractional_select,
	output reg [2:0] filter_cap_three_code,
	output reg secondary_doubler_enable,
	output reg [1:0] margin_option,
	output reg [9:0] step_one_offset_value,
	output reg [9:0] software_offset_value,
	output wire [2:0] margin_step_applied,
	output wire margin_software_mode
);

	// ****************************************
	// Address decode
	// ****************************************
	function is_mapped;
		input [9:0] idx;
		begin
			case (idx)
				`PFM_IDX_CAP_ONE,
				`PFM_IDX_RES_THREE,
				`PFM_IDX_CAP_THREE,
				`PFM_IDX_SECONDARY_REF_CONTROL,
				`PFM_IDX_MARGIN_CTRL,
				`PFM_IDX_STEP_ONE_HIGH,
				`PFM_IDX_STEP_ONE_LOW,
				`PFM_IDX_SW_HIGH,
				`PFM_IDX_SW_LOW: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	reg sec_reserved_high;
	reg [3:0] sec_reserved_low;
	reg aw_full;
	reg w_full;
	reg [9:0] aw_index;
	reg [7:0] w_byte;
	reg w_lane;
	reg [7:0] read_byte;
	wire [3:0] pin_level;
	wire [2:0] step_level;
	wire gate_level;
	wire do_write;
	wire store_en;
	wire [9:0] ar_index;

	assign step_level = pin_level[2:0];
	assign gate_level = pin_level[3];
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign ar_index = s_axi_araddr[11:2];

	// ****************************************
	// Pin synchroniser and source choice
	// ****************************************
	pfm_pin_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in({margin_gate_pin, margin_step_pin}),
		.pin_level(pin_level)
	);

	pfm_margin_sel u_margin_sel (
		.aclk(aclk),
		.aresetn(aresetn),
		.option(margin_option),
		.gate_level(gate_level),
		.step_level(step_level),
		.applied_step(margin_step_applied),
		.use_software(margin_software_mode)
	);

	// ****************************************
	// Write channels
	// ****************************************
	// Address and data may arrive in either order; each is held until both are in
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_index <= 10'h000;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PFM_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_index <= s_axi_awaddr[11:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_index) ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ****************************************
	// Register storage
	// ****************************************
	// Only the low byte lane carries data; upper lanes are ignored
	assign store_en = do_write && w_lane;

	always @(posedge aclk) begin
		if (!aresetn) begin
			filter_cap_one_code <= `PFM_RST_CAP_CODE;
		end else if (store_en && aw_index == `PFM_IDX_CAP_ONE) begin
			filter_cap_one_code <= w_byte[`PFM_CAP_CODE_MSB:0];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			filter_res_three_code <= `PFM_RST_RES_CODE;
			filter_fractional_select <= `PFM_RST_FRAC;
		end else if (store_en && aw_index == `PFM_IDX_RES_THREE) begin
			filter_res_three_code <= w_byte[`PFM_RES_CODE_MSB:`PFM_RES_CODE_LSB];
			filter_fractional_select <= w_byte[`PFM_FRAC_BIT];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			filter_cap_three_code <= `PFM_RST_CAP_CODE;
		end else if (store_en && aw_index == `PFM_IDX_CAP_THREE) begin
			filter_cap_three_code <= w_byte[`PFM_CAP_CODE_MSB:0];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			secondary_doubler_enable <= `PFM_RST_DOUBLER;
		end else if (store_en && aw_index == `PFM_IDX_SECONDARY_REF_CONTROL) begin
			secondary_doubler_enable <= w_byte[`PFM_DOUBLER_BIT];
		end
	end

	// Reserved bits are kept so software reads back what it wrote
	always @(posedge aclk) begin
		if (!aresetn) begin
			sec_reserved_high <= `PFM_RST_SEC_RSV_HI;
			sec_reserved_low <= `PFM_RST_SEC_RSV_LO;
		end else if (store_en && aw_index == `PFM_IDX_SECONDARY_REF_CONTROL) begin
			sec_reserved_high <= w_byte[`PFM_SEC_RSV_HI_BIT];
			sec_reserved_low <= w_byte[`PFM_SEC_RSV_LO_MSB:0];
		end
	end

	// Readback field is read-only; write bits there are dropped
	always @(posedge aclk) begin
		if (!aresetn) begin
			margin_option <= `PFM_RST_OPTION;
		end else if (store_en && aw_index == `PFM_IDX_MARGIN_CTRL) begin
			margin_option <= w_byte[`PFM_OPTION_MSB:`PFM_OPTION_LSB];
		end
	end

	// Halves are written one at a time, so a pair update is not atomic
	always @(posedge aclk) begin
		if (!aresetn) begin
			step_one_offset_value <= {`PFM_RST_STEP_ONE_HIGH, `PFM_RST_STEP_ONE_LOW};
		end else if (store_en && aw_index == `PFM_IDX_STEP_ONE_HIGH) begin
			step_one_offset_value[9:8] <= w_byte[`PFM_OFFSET_HIGH_MSB:0];
		end else if (store_en && aw_index == `PFM_IDX_STEP_ONE_LOW) begin
			step_one_offset_value[7:0] <= w_byte;
		end
	end

	// Software offset only matters while option 2 is selected
	always @(posedge aclk) begin
		if (!aresetn) begin
			software_offset_value <= {`PFM_RST_SW_HIGH, `PFM_RST_SW_LOW};
		end else if (store_en && aw_index == `PFM_IDX_SW_HIGH) begin
			software_offset_value[9:8] <= w_byte[`PFM_OFFSET_HIGH_MSB:0];
		end else if (store_en && aw_index == `PFM_IDX_SW_LOW) begin
			software_offset_value[7:0] <= w_byte;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always @* begin
		read_byte = 8'h00;
		case (ar_index)
			`PFM_IDX_CAP_ONE: begin
				read_byte = {5'h00, filter_cap_one_code};
			end
			`PFM_IDX_RES_THREE: begin
				read_byte = {1'b0, filter_res_three_code, filter_fractional_select};
			end
			`PFM_IDX_CAP_THREE: begin
				read_byte = {5'h00, filter_cap_three_code};
			end
			`PFM_IDX_SECONDARY_REF_CONTROL: begin
				read_byte = {2'h0, sec_reserved_high, secondary_doubler_enable, sec_reserved_low};
			end
			`PFM_IDX_MARGIN_CTRL: begin
				read_byte = {1'b0, step_level, margin_option, 2'h0};
			end
			`PFM_IDX_STEP_ONE_HIGH: begin
				read_byte = {6'h00, step_one_offset_value[9:8]};
			end
			`PFM_IDX_STEP_ONE_LOW: begin
				read_byte = step_one_offset_value[7:0];
			end
			`PFM_IDX_SW_HIGH: begin
				read_byte = {6'h00, software_offset_value[9:8]};
			end
			`PFM_IDX_SW_LOW: begin
				read_byte = software_offset_value[7:0];
			end
			default: begin
				read_byte = 8'h00;
			end
		endcase
	end

	// ****************************************
	// Read channels
	// ****************************************
	// Data sampled at the address edge, held stable until rready
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PFM_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, read_byte};
				s_axi_rresp <= is_mapped(ar_index) ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // pfm_regs

/* File: testbench/pfm_regs_checker.sv */
`timescale 1ns/1ps
module pfm_regs_checker (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire margin_gate_pin,
	input wire [2:0] margin_step_pin,
	input wire [1:0] margin_option,
	input wire [2:0] margin_step_applied,
	input wire margin_software_mode
);
	// ****************
	// Bus and margin checks
	// ****************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not on second edge");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_soft_mode: assert property (1'b1 |=> margin_software_mode == ($past(margin_option) == 2'h2))
		else $error("software mode wrong");
	// Pins must sit still a while, sync only updates on a settled vector
	a_gate_nominal: assert property ((margin_option == 2'h0 && margin_gate_pin
		&& $stable(margin_step_pin))[*6] |=> margin_step_applied == 3'h3) else $error("gate high not nominal");
	a_pin_step: assert property (((margin_option == 2'h1 || margin_option == 2'h0 && !margin_gate_pin)
		&& $stable(margin_gate_pin) && $stable(margin_step_pin) && $stable(margin_option))[*6]
		|=> margin_step_applied == $past(margin_step_pin)) else $error("pin step not applied");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_soft: cover property (margin_software_mode);
endmodule // pfm_regs_checker

bind pfm_regs pfm_regs_checker chk_i (.*);

/* File: testbench/pfm_regs_bench.sv */
`timescale 1ns/1ps
module pfm_regs_bench;
	logic aclk = 0;
	logic aresetn = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, margin_option;
	logic margin_gate_pin = 1;
	logic [2:0] margin_step_pin = 0, filter_cap_one_code, filter_cap_three_code, margin_step_applied;
	logic [5:0] filter_res_three_code;
	logic filter_fractional_select, secondary_doubler_enable, margin_software_mode;
	logic [9:0] step_one_offset_value, software_offset_value;
	int miscompares = 0, n_compared = 0;
	logic [9:0] ix [9] = '{10'h044, 10'h045, 10'h046, 10'h048, 10'h056, 10'h058, 10'h059, 10'h068, 10'h069};
	logic [9:0] ux [3] = '{10'h047, 10'h057, 10'h3ff};
	logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'hde, 8'h00, 8'h00};
	logic [7:0] mk [9] = '{8'h07, 8'h7f, 8'h07, 8'h3f, 8'h0c, 8'h03, 8'hff, 8'h03, 8'hff};
	logic [7:0] cur [9];

	pfm_regs dut (.*);

	initial forever #12.5 aclk = ~aclk;

	// ****************
	// Checking and bus tasks
	// ****************
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tmo(input int k);
		if (k == 40) begin
			miscompares++;
			tally_and_finish;
		end
	endtask

	task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'($urandom), d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		tmo(k);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask

	task automatic rd(input logic [9:0] i, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		tmo(k);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	// Write and track what should now be stored
	task automatic wm(input int j, input logic [7:0] d, input logic [3:0] s);
		logic [1:0] r;
		wr(ix[j], d, s, r);
		chk("bresp", r, 2'h0);
		if (s[0]) cur[j] = d & mk[j];
	endtask

	task automatic rm(input int j);
		logic [31:0] d;
		logic [1:0] r;
		rd(ix[j], d, r);
		chk("rresp", r, 2'h0);
		chk("rdata", d, cur[j] | (j == 4 ? {1'b0, margin_step_pin, 4'h0} : 8'h00));
		chk("fields", {filter_cap_one_code, filter_res_three_code, filter_fractional_select, filter_cap_three_code,
			secondary_doubler_enable, margin_option, step_one_offset_value, software_offset_value},
			{cur[0][2:0], cur[1][6:0], cur[2][2:0], cur[3][4], cur[4][3:2], cur[5][1:0], cur[6],
			cur[7][1:0], cur[8]});
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		int j, o, g;
		logic [7:0] d;
		logic [31:0] q;
		logic [1:0] r;
		void'($urandom(32'h6f84_b875));
		cur = rv;
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		for (j = 0; j < 9; j++) rm(j);
		for (int n = 0; n < 60; n++) begin
			j = n < 9 ? n : $urandom_range(8);
			wm(j, n < 9 ? 8'hff : 8'($urandom), n < 9 ? 4'hf : 4'($urandom));
			rm(j);
		end
		for (j = 0; j < 3; j++) begin
			wr(ux[j], 8'hff, 4'hf, r);
			chk("bresp bad", r, 2'h2);
			rd(ux[j], q, r);
			chk("rresp bad", {r, q}, {2'h2, 32'h0});
		end
		for (o = 0; o < 4; o++) for (g = 0; g < 2; g++) begin
			d = 8'($urandom_range(7));
			wm(4, {4'h0, o[1:0], 2'h0}, 4'h1);
			margin_gate_pin <= g[0];
			margin_step_pin <= d[2:0];
			repeat (8) @(posedge aclk);
			rm(4);
			chk("soft mode", margin_software_mode, o == 2);
			if (o != 2) chk("step", margin_step_applied, (o == 3 || (o == 0 && g)) ? 3'h3 : d[2:0]);
		end
		// Second reset mid-run must restore every field
		aresetn <= 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		cur = rv;
		repeat (6) @(posedge aclk);
		for (j = 0; j < 9; j++) rm(j);
		tally_and_finish;
	end
endmodule // pfm_regs_bench
